// *** bench/fabric_user.sv ***
module fabric_user (
  input  wire logic                 mclk,
  input  wire dpram_pkg::port_req_t cmd,
  output dpram_pkg::port_req_t      req
);
  timeunit 1ns;
  timeprecision 1ns;
  import dpram_pkg::*;
  logic [DATA_W-1:0] last;
  // Remember the last data driven while the port was in use
  always_ff @(posedge mclk) begin
    if (cmd.en) last <= cmd.din;
  end
  // Idle data lines show the inverse, so a stale value never looks valid
  always_comb begin
    req = cmd;
    if (!cmd.en) req.din = ~last;
  end
endmodule // fabric_user

// *** bench/tb_dual_port_block_ram.sv ***
module tb_dual_port_block_ram;
  timeunit 1ns;
  timeprecision 1ns;
  import dpram_pkg::*;
  logic              mclk;
  logic              resetn;
  logic              ce;
  port_req_t         pa;
  port_req_t         cmd_b;
  port_req_t         pb;
  logic [DATA_W-1:0] dout_a;
  logic [DATA_W-1:0] dout_b;
  int                num_errors;
  int                checks;
  dual_port_block_ram dut (.mclk(mclk), .resetn(resetn), .ce(ce), .port_a(pa),
                           .port_b(pb), .dout_a(dout_a), .dout_b(dout_b));
  fabric_user far_b (.mclk(mclk), .cmd(cmd_b), .req(pb));
  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Compare one output against its expected word, counting the check
  task automatic judge(input bit b, input logic [15:0] e);
    logic [15:0] got;
    got = b ? dout_b : dout_a;
    checks++;
    if (got !== e) begin
      num_errors++;
      $display("BAD dout_%s exp %h got %h", b ? "b" : "a", e, got);
    end
  endtask
  // One access on a port for one cycle; read data is judged after the edge
  task automatic op(input bit b, input bit w, input width_t ws, input logic [11:0] ad,
                    input logic [15:0] d, input bit chk, input logic [15:0] e);
    @(posedge mclk);
    if (b) cmd_b <= '{1'b1, w, ws, ad, d};
    else pa <= '{1'b1, w, ws, ad, d};
    @(posedge mclk);
    cmd_b.en <= 1'b0;
    pa.en <= 1'b0;
    #1;
    if (chk) judge(b, e);
  endtask
  // Byte written on A, read back bit by bit on B
  task automatic t_conv;
    op(0, 1, WID_8, 12'h000, 16'h00A5, 0, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      op(1, 0, WID_1, 12'(i), 16'h0000, 1, {15'h0, 1'(16'h00A5 >> i)});
    end
  endtask
  // Top word written on B, read back as the last four nibbles on A
  task automatic t_deep;
    op(1, 1, WID_16, 12'h0FF, 16'h1234, 0, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      op(0, 0, WID_4, 12'h3FC + 12'(i), 16'h0000, 1, 16'(4 - i));
    end
  endtask
  // Two-bit write on A, first bit read on B in the very next edge, then the second
  task automatic t_cross;
    @(posedge mclk);
    pa <= '{1'b1, 1'b1, WID_2, 12'h040, 16'h0001};
    @(posedge mclk);
    pa.en <= 1'b0;
    cmd_b <= '{1'b1, 1'b0, WID_1, 12'h080, 16'h0000};
    @(posedge mclk);
    cmd_b.en <= 1'b0;
    #1;
    judge(1, 16'h0001);
    op(1, 0, WID_1, 12'h081, 16'h0000, 1, 16'h0000);
  endtask
  // Both ports write one word in the same edge twice; port B must win
  task automatic t_clash;
    @(posedge mclk);
    pa <= '{1'b1, 1'b1, WID_16, 12'h010, 16'h1111};
    cmd_b <= '{1'b1, 1'b1, WID_16, 12'h010, 16'h2222};
    @(posedge mclk);
    pa.din <= 16'h3333;
    cmd_b.din <= 16'h4444;
    @(posedge mclk);
    pa.en <= 1'b0;
    cmd_b.en <= 1'b0;
    #1;
    judge(0, 16'h2222);
    judge(1, 16'h2222);
    // Unused code acts as width 16, high address bits are ignored
    op(0, 0, width_t'(3'h5), 12'hF10, 16'h0000, 1, 16'h4444);
  endtask
  // With the clock enable low neither a write lands nor an output moves
  task automatic t_hold;
    op(0, 1, WID_16, 12'h005, 16'hBEEF, 0, 16'h0000);
    op(0, 0, WID_16, 12'h005, 16'h0000, 1, 16'hBEEF);
    @(posedge mclk);
    ce <= 1'b0;
    op(0, 0, WID_16, 12'h010, 16'h0000, 1, 16'hBEEF);
    op(1, 1, WID_16, 12'h005, 16'h5A5A, 0, 16'h0000);
    @(posedge mclk);
    ce <= 1'b1;
    op(0, 0, WID_16, 12'h005, 16'h0000, 1, 16'hBEEF);
  endtask
  // Reset in mid-run clears the outputs but leaves the stored words alone
  task automatic t_reset;
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    judge(0, 16'h0000);
    judge(1, 16'h0000);
    op(1, 0, WID_16, 12'h005, 16'h0000, 1, 16'hBEEF);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic stop_test;
    if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Reset, then the scenarios in turn
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    pa = '0;
    cmd_b = '0;
    num_errors = 0;
    checks = 0;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    t_conv();
    t_deep();
    t_cross();
    t_clash();
    t_hold();
    t_reset();
    stop_test();
  end
endmodule // tb_dual_port_block_ram

// *** rtl/dpram_pkg.sv ***
package dpram_pkg;

  // Storage and bus geometry
  localparam int MEM_BITS  = 4096;
  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 16;
  localparam int SHIFT_W   = 3;

  // Output word after reset
  localparam logic [15:0] DOUT_RESET = 16'h0000;

  // Port aspect ratio: the code is log2 of the word width
  typedef enum logic [2:0] {
    WID_1  = 3'h0,
    WID_2  = 3'h1,
    WID_4  = 3'h2,
    WID_8  = 3'h3,
    WID_16 = 3'h4
  } width_t;

  // One port's complete set of controls
  typedef struct packed {
    logic                en;
    logic                we;
    width_t              wsel;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   din;
  } port_req_t;

endpackage

// *** rtl/dual_port_block_ram.sv ***
module dual_port_block_ram (
  input  wire logic                    mclk,
  input  wire logic                    resetn,
  input  wire logic                    ce,
  input  wire dpram_pkg::port_req_t    port_a,
  input  wire dpram_pkg::port_req_t    port_b,
  output logic [dpram_pkg::DATA_W-1:0] dout_a,
  output logic [dpram_pkg::DATA_W-1:0] dout_b
);
  import dpram_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Storage and decode helpers

  // No reset on the array: contents are undefined until written
  logic mem [0:MEM_BITS-1];

  // Codes above the widest ratio are folded onto width 16
  function automatic logic [SHIFT_W-1:0] shift_of(input width_t sel);
    logic [SHIFT_W-1:0] s;
    s = (sel > WID_16) ? SHIFT_W'(WID_16) : SHIFT_W'(sel);
    return s;
  endfunction

  // Lanes of the data bus in use at a given width
  function automatic logic [DATA_W-1:0] lane_mask(input width_t sel);
    logic [DATA_W-1:0] m;
    unique case (shift_of(sel))
      3'h0:    m = 16'h0001;
      3'h1:    m = 16'h0003;
      3'h2:    m = 16'h000F;
      3'h3:    m = 16'h00FF;
      default: m = 16'hFFFF;
    endcase
    return m;
  endfunction

  // First bit of a word; high address bits fall off the top with the shift
  function automatic logic [ADDR_W-1:0] word_base(input logic [ADDR_W-1:0] addr,
                                                  input width_t            sel);
    logic [ADDR_W-1:0] b;
    b = ADDR_W'(addr << shift_of(sel));
    return b;
  endfunction

  // Gather one word from the store, unused lanes read zero
  function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] base,
                                                  input width_t            sel);
    logic [DATA_W-1:0] w;
    logic [DATA_W-1:0] m;
    w = '0;
    m = lane_mask(sel);
    for (int k = 0; k < DATA_W; k++) begin
      if (m[k]) begin
        w[k] = mem[base + ADDR_W'(k)];
      end
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Per-port decode

  logic [ADDR_W-1:0] base_a;
  logic [ADDR_W-1:0] base_b;
  logic [DATA_W-1:0] mask_a;
  logic [DATA_W-1:0] mask_b;
  logic              wr_a;
  logic              wr_b;
  logic              rd_a;
  logic              rd_b;
  logic [DATA_W-1:0] next_dout_a;
  logic [DATA_W-1:0] next_dout_b;

  // Each port decodes its own controls, gated by the shared ce
  always_comb begin
    base_a      = word_base(port_a.addr, port_a.wsel);
    base_b      = word_base(port_b.addr, port_b.wsel);
    mask_a      = lane_mask(port_a.wsel);
    mask_b      = lane_mask(port_b.wsel);
    wr_a        = ce && port_a.en && port_a.we;
    wr_b        = ce && port_b.en && port_b.we;
    rd_a        = ce && port_a.en;
    rd_b        = ce && port_b.en;
    next_dout_a = read_word(base_a, port_a.wsel);
    next_dout_b = read_word(base_b, port_b.wsel);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array writes

  // Both ports write here so the array keeps one driver; within each lane k B lands last,
  // so port B wins a bit written by both ports in one edge unless port A reaches it from a higher lane than port B
  always_ff @(posedge mclk) begin
    for (int k = 0; k < DATA_W; k++) begin
      if (wr_a && mask_a[k]) begin
        mem[base_a + ADDR_W'(k)] <= port_a.din[k];
      end
      if (wr_b && mask_b[k]) begin
        mem[base_b + ADDR_W'(k)] <= port_b.din[k];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers

  // Read-before-write: a write also returns the old word at that address
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dout_a <= DOUT_RESET;
    end else if (rd_a) begin
      dout_a <= next_dout_a;
    end
  end

  // Port B output register, held while the port is idle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dout_b <= DOUT_RESET;
    end else if (rd_b) begin
      dout_b <= next_dout_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Last lone write on port A, for checking where the bits landed
  logic              chk_vld;
  logic [ADDR_W-1:0] chk_base;
  width_t            chk_sel;
  logic [DATA_W-1:0] chk_din;
  logic [DATA_W-1:0] chk_word;

  // Last write on port B; B wins same-lane collisions, and its word is checked to land whole every time
  logic              chk_b_vld;
  logic [ADDR_W-1:0] chk_b_base;
  width_t            chk_b_sel;
  logic [DATA_W-1:0] chk_b_din;
  logic [DATA_W-1:0] chk_b_word;

  // Captured whenever ce is high; valid only when port A writes and port B does not
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      chk_vld  <= 1'b0;
      chk_base <= '0;
      chk_sel  <= WID_1;
      chk_din  <= '0;
    end else if (ce) begin
      chk_vld  <= wr_a && !wr_b;
      chk_base <= base_a;
      chk_sel  <= port_a.wsel;
      chk_din  <= port_a.din;
    end
  end

  // Port B capture, frozen with the rest of the state while ce is low
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      chk_b_vld  <= 1'b0;
      chk_b_base <= '0;
      chk_b_sel  <= WID_1;
      chk_b_din  <= '0;
    end else if (ce) begin
      chk_b_vld  <= wr_b;
      chk_b_base <= base_b;
      chk_b_sel  <= port_b.wsel;
      chk_b_din  <= port_b.din;
    end
  end

  // Stored words read back combinationally, so the checks see the array
  // as it stood just before the edge at which they are sampled
  always_comb begin
    chk_word   = read_word(chk_base, chk_sel);
    chk_b_word = read_word(chk_b_base, chk_b_sel);
  end

  read_timing_a: assert property (@(posedge mclk) disable iff (!resetn)
    rd_a |=> dout_a == $past(next_dout_a))
    else $error("port A read word not presented one edge later");

  read_timing_b: assert property (@(posedge mclk) disable iff (!resetn)
    rd_b |=> dout_b == $past(next_dout_b))
    else $error("port B read word not presented one edge later");

  idle_hold_b_a: assert property (@(posedge mclk) disable iff (!resetn)
    !rd_b |=> $stable(dout_b))
    else $error("port B output moved while port B idle");

  freeze_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    !ce |=> $stable(dout_a) && $stable(dout_b))
    else $error("outputs moved while clock enable low");

  lane_zero_a: assert property (@(posedge mclk) disable iff (!resetn)
    rd_a |=> (dout_a & ~lane_mask($past(port_a.wsel))) == 16'h0000)
    else $error("port A unused lanes not zero");

  write_place_a: assert property (@(posedge mclk) disable iff (!resetn)
    chk_vld |-> chk_word == (chk_din & lane_mask(chk_sel)))
    else $error("port A write did not land at address times width");

  cross_width_a: assert property (@(posedge mclk) disable iff (!resetn)
    chk_vld && rd_b && !wr_b && port_b.wsel == WID_1
      && port_b.addr == chk_base
    |=> dout_b[0] == $past(chk_din[0]))
    else $error("narrow port B read missed port A wide write");

  idle_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    !rd_a |=> $stable(dout_a))
    else $error("port A output moved while port A idle");

  lane_zero_b_a: assert property (@(posedge mclk) disable iff (!resetn)
    rd_b |=> (dout_b & ~lane_mask($past(port_b.wsel))) == 16'h0000)
    else $error("port B unused lanes not zero");

  write_place_b_a: assert property (@(posedge mclk) disable iff (!resetn)
    chk_b_vld |-> chk_b_word == (chk_b_din & lane_mask(chk_b_sel)))
    else $error("port B write did not land at address times width");

  reset_clear_a: assert property (@(posedge mclk)
    !resetn && $past(!resetn) |-> dout_a == DOUT_RESET && dout_b == DOUT_RESET)
    else $error("outputs not cleared during reset");

endmodule // dual_port_block_ram
